// ---- rtl/dsas_top.sv ----
// dual-slope converter sequencer: phase control, result capture, serial out
// assumes all converter and host pins are asynchronous to i_clk
//
// Overview of operation
// - start input low begins a conversion cycle
// - result with flags kept in 18-bit register
// - result_ready asserts when each cycle starts
// - result_ready serves as poll line or interrupt
// - host may read anytime, any serial rate
// - device drives phases and watches comparator itself
// - comparator falling edge ends reference rundown
// - integrator clear phase lasts 0.5 ms
// - auto zero held 100 ms after power-up
// - phase codes 01 AZ,10 INT,11 RUN,00 CLR
// - read falling loads word, overflow first
// - data out driven only while read low
// - shift in on rising, out on falling
`timescale 1ns/10ps
module dsas_top #(
	parameter int P_AZ_CYCLES  = dsas_pkg::AZ_PWRUP_CYCLES,
	parameter int P_CLR_CYCLES = dsas_pkg::CLR_CYCLES,
	parameter int P_INT_CYCLES = dsas_pkg::INT_CYCLES
) (
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_sys_rst,
	// converter side
	input  wire logic        i_start_n,
	input  wire logic        i_zero_cross_in,
	output logic             o_phase_upper,
	output logic             o_phase_lower,
	// host side
	output logic             o_result_ready,
	input  wire logic        i_serial_clock,
	input  wire logic        i_read_n,
	input  wire logic        i_serial_din,
	output logic             o_dout,
	output logic             o_dout_oe_n,
	output logic [15:0]      o_rx_word
);

	localparam int TW = dsas_pkg::TIMER_W;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		dsas_pkg::dsas_state_t         state;
		logic [TW-1:0]                 timer;
		logic [dsas_pkg::MAG_W-1:0]    count;
		logic                          sign;
		dsas_pkg::dsas_result_t        cap;
		dsas_pkg::dsas_result_t        result;
		dsas_pkg::dsas_result_t        pub;
		logic                          ready;
		logic [1:0]                    phase;
		logic [2:0]                    zc_sync;
		logic [2:0]                    start_sync;
		logic [2:0]                    read_sync;
	} dsas_st_t;

	dsas_st_t r;
	dsas_st_t n;

	logic start_low;
	logic zc_fall;
	logic read_begin;
	logic reading;

	// bit 0 of each synchroniser is the first flop, read only by bit 1
	assign start_low  = ~r.start_sync[1];
	assign zc_fall    = r.zc_sync[2] & ~r.zc_sync[1];
	assign reading    = ~r.read_sync[1];
	assign read_begin = r.read_sync[2] & ~r.read_sync[1];

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		n = r;
		n.zc_sync    = {r.zc_sync[1:0], i_zero_cross_in};
		n.start_sync = {r.start_sync[1:0], i_start_n};
		n.read_sync  = {r.read_sync[1:0], i_read_n};
		n.timer      = r.timer + 1'b1;
		// the host taking the word acknowledges the ready line
		if (read_begin) begin
			n.ready = 1'b0;
		end
		case (r.state)
			dsas_pkg::ST_POWERUP: begin
				if (r.timer == TW'(P_AZ_CYCLES - 1)) begin
					n.state = dsas_pkg::ST_AUTO_ZERO;
				end
			end
			dsas_pkg::ST_AUTO_ZERO: begin
				// a held-low start runs cycles back to back
				if (start_low) begin
					n.state  = dsas_pkg::ST_INTEGRATE;
					n.timer  = '0;
					n.result = r.cap;
					n.ready  = 1'b1;  // set wins over read
				end
			end
			dsas_pkg::ST_INTEGRATE: begin
				if (r.timer == TW'(P_INT_CYCLES - 1)) begin
					n.state = dsas_pkg::ST_REFERENCE_RUNDOWN;
					n.count = '0;
					// comparator level on entry tells the input sign
					n.sign  = r.zc_sync[1];
				end
			end
			dsas_pkg::ST_REFERENCE_RUNDOWN: begin
				if (zc_fall) begin
					n.state = dsas_pkg::ST_INTEGRATOR_CLEAR;
					n.timer = '0;
					n.cap   = {1'b0, r.sign, r.count};
				end else if (r.count == dsas_pkg::MAG_FULL_SCALE) begin
					n.state = dsas_pkg::ST_INTEGRATOR_CLEAR;
					n.timer = '0;
					n.cap   = {1'b1, r.sign, r.count};
				end else begin
					n.count = r.count + 1'b1;
				end
			end
			dsas_pkg::ST_INTEGRATOR_CLEAR: begin
				if (r.timer == TW'(P_CLR_CYCLES - 1)) begin
					n.state = dsas_pkg::ST_AUTO_ZERO;
				end
			end
			default: begin
				n.state = dsas_pkg::ST_POWERUP;
				n.timer = '0;
			end
		endcase
		// the published word freezes for the whole read, which is the
		// word crossing to the serial clock; a read started within two
		// clocks of an update may catch the newer word
		if (!reading) begin
			n.pub = n.result;
		end
		// phase select follows the state without host help
		case (n.state)
			dsas_pkg::ST_INTEGRATE:         n.phase = dsas_pkg::PH_INTEGRATE;
			dsas_pkg::ST_REFERENCE_RUNDOWN: n.phase = dsas_pkg::PH_RUNDOWN;
			dsas_pkg::ST_INTEGRATOR_CLEAR:  n.phase = dsas_pkg::PH_CLEAR;
			default:                        n.phase = dsas_pkg::PH_AUTO_ZERO;
		endcase
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			r            <= '0;
			r.state      <= dsas_pkg::ST_POWERUP;
			r.cap        <= dsas_pkg::RESULT_RST;
			r.result     <= dsas_pkg::RESULT_RST;
			r.pub        <= dsas_pkg::RESULT_RST;
			r.phase      <= dsas_pkg::PH_AUTO_ZERO;
			r.zc_sync    <= dsas_pkg::SYNC_LOW;
			r.start_sync <= dsas_pkg::SYNC_HIGH;
			r.read_sync  <= dsas_pkg::SYNC_HIGH;
		end else begin
			r <= n;
		end
	end

	assign o_phase_upper  = r.phase[1];
	assign o_phase_lower  = r.phase[0];
	assign o_result_ready = r.ready;

	// ------------------------------------------------------------
	// serial port on the host clock
	// ------------------------------------------------------------
	dsas_if word_if ();
	assign word_if.word = r.pub;

	dsas_serial u_serial (
		.lnk            (word_if.link_mp),
		.i_serial_clock (i_serial_clock),
		.i_read_n       (i_read_n),
		.i_serial_din   (i_serial_din),
		.i_sys_rst      (i_sys_rst),
		.o_dout         (o_dout),
		.o_dout_oe_n    (o_dout_oe_n),
		.o_rx_word      (o_rx_word)
	);

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_sys_rst);

	start_begins_a: assert property (
		r.state == dsas_pkg::ST_AUTO_ZERO && start_low
		|=> r.state == dsas_pkg::ST_INTEGRATE && r.timer == '0)
		else $error("start low did not begin integrate");

	result_hold_a: assert property (
		!(r.state == dsas_pkg::ST_AUTO_ZERO && start_low)
		|=> $stable(r.result))
		else $error("result changed outside cycle start");

	ready_at_start_a: assert property (
		$rose(r.ready) |-> r.state == dsas_pkg::ST_INTEGRATE
		&& $past(r.state) == dsas_pkg::ST_AUTO_ZERO
		&& r.result == $past(r.cap))
		else $error("ready rose without a cycle start");

	ready_ack_a: assert property (
		read_begin && r.state != dsas_pkg::ST_AUTO_ZERO |=> !r.ready)
		else $error("read did not clear ready");

	word_frozen_a: assert property (
		reading && $past(reading) |-> $stable(r.pub))
		else $error("published word moved during read");

	phase_code_a: assert property (
		##1 (r.state == dsas_pkg::ST_REFERENCE_RUNDOWN)
		== (o_phase_upper && o_phase_lower))
		else $error("rundown phase code wrong");

	rundown_end_a: assert property (
		r.state == dsas_pkg::ST_REFERENCE_RUNDOWN && zc_fall
		|=> r.state == dsas_pkg::ST_INTEGRATOR_CLEAR
		&& r.cap.magnitude == $past(r.count) && !r.cap.overflow_flag)
		else $error("comparator fall did not end rundown");

	overflow_a: assert property (
		r.state == dsas_pkg::ST_REFERENCE_RUNDOWN && !zc_fall
		&& r.count == dsas_pkg::MAG_FULL_SCALE
		|=> r.cap.overflow_flag && !o_phase_upper && !o_phase_lower)
		else $error("full scale did not set overflow");

	clear_len_a: assert property (
		r.state == dsas_pkg::ST_INTEGRATOR_CLEAR
		|-> r.timer <= TW'(P_CLR_CYCLES - 1))
		else $error("integrator clear too long");

	clear_min_a: assert property (
		r.state == dsas_pkg::ST_INTEGRATOR_CLEAR
		&& r.timer < TW'(P_CLR_CYCLES - 1)
		|=> r.state == dsas_pkg::ST_INTEGRATOR_CLEAR)
		else $error("integrator clear ended early");

	powerup_hold_a: assert property (
		r.state == dsas_pkg::ST_POWERUP
		|-> !o_phase_upper && o_phase_lower && !r.ready
		&& r.timer <= TW'(P_AZ_CYCLES - 1))
		else $error("power-up auto zero broken");

	// read high must release the pin and park the index on the first bit
	oe_follows_a: assert property (
		i_read_n |-> o_dout_oe_n && u_serial.tx_reg.idx == '0
		&& o_dout == r.pub.overflow_flag)
		else $error("serial port not idle with read high");

	conv_done_c:  cover property (
		r.state == dsas_pkg::ST_REFERENCE_RUNDOWN && zc_fall);
	overflow_c:   cover property (
		r.state == dsas_pkg::ST_INTEGRATOR_CLEAR && r.cap.overflow_flag);
	read_busy_c:  cover property (
		reading && r.state == dsas_pkg::ST_INTEGRATE);

endmodule

// ---- common/dsas_pkg.sv ----
// constants, result layout and states of the dual-slope sequencer
// assumes the system clock runs at 20 MHz; times derive cycle counts from it
package dsas_pkg;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int  CLK_PERIOD_NS    = 50;
	localparam real CLR_TIME_MS      = 0.5;
	localparam real AZ_PWRUP_TIME_MS = 100.0;
	// least times, so round up to whole cycles
	localparam int  CLR_CYCLES       =
		int'($ceil(CLR_TIME_MS * 1.0e6 / CLK_PERIOD_NS));
	localparam int  AZ_PWRUP_CYCLES  =
		int'($ceil(AZ_PWRUP_TIME_MS * 1.0e6 / CLK_PERIOD_NS));
	// integrate length in timebase clocks, one full magnitude span
	localparam int  INT_CYCLES       = 65536;
	localparam int  TIMER_W          = 21;

	// ------------------------------------------------------------
	// result word, sent overflow first, sign next, magnitude msb first
	// ------------------------------------------------------------
	localparam int          MAG_W          = 16;
	localparam int          RESULT_W       = 18;
	localparam logic [15:0] MAG_FULL_SCALE = 16'hFFFF;
	typedef struct packed {
		logic              overflow_flag;
		logic              sign_flag;
		logic [MAG_W-1:0]  magnitude;
	} dsas_result_t;
	localparam dsas_result_t RESULT_RST = '0;

	// serial bit index: bit 0 is the overflow flag, 18 means exhausted
	localparam int         BIT_IDX_W = 5;
	localparam logic [4:0] LAST_BIT  = 5'h11;
	localparam logic [4:0] END_BIT   = 5'h12;

	// ------------------------------------------------------------
	// phase-select codes {upper, lower}
	// ------------------------------------------------------------
	localparam logic [1:0] PH_AUTO_ZERO = 2'h1;
	localparam logic [1:0] PH_INTEGRATE = 2'h2;
	localparam logic [1:0] PH_RUNDOWN   = 2'h3;
	localparam logic [1:0] PH_CLEAR     = 2'h0;

	// synchroniser idle values
	localparam logic [2:0] SYNC_HIGH = 3'h7;
	localparam logic [2:0] SYNC_LOW  = 3'h0;

	// ------------------------------------------------------------
	// sequencer states
	// ------------------------------------------------------------
	typedef enum logic [4:0] {
		ST_POWERUP                 = 5'h01,
		ST_AUTO_ZERO               = 5'h02,
		ST_INTEGRATE               = 5'h04,
		ST_REFERENCE_RUNDOWN       = 5'h08,
		ST_INTEGRATOR_CLEAR        = 5'h10
	} dsas_state_t;

endpackage

// ---- common/dsas_if.sv ----
// carries the published result word from the sequencer to the serial port
// assumes the word is held still while a read is in progress
`timescale 1ns/10ps
interface dsas_if;
	dsas_pkg::dsas_result_t word;
	modport sys_mp  (output word);
	modport link_mp (input  word);
endinterface

// ---- rtl/dsas_serial.sv ----
// serial output port, clocked by the host's serial clock
// assumes the published word is quasi-static during a read access
`timescale 1ns/10ps
module dsas_serial (
	// word from the sequencer
	dsas_if.link_mp                lnk,
	// host serial pins
	input  wire logic              i_serial_clock,
	input  wire logic              i_read_n,
	input  wire logic              i_serial_din,
	input  wire logic              i_sys_rst,
	output logic                   o_dout,
	output logic                   o_dout_oe_n,
	output logic [15:0]            o_rx_word
);

	// ------------------------------------------------------------
	// output side, advances on falling serial clock edges
	// ------------------------------------------------------------
	typedef struct packed {
		logic [dsas_pkg::BIT_IDX_W-1:0] idx;
	} dsas_tx_st_t;
	dsas_tx_st_t tx_reg;
	dsas_tx_st_t tx_next;

	// read high holds the index at the overflow bit, so it is ready
	// at the pin the moment read falls, before any clock edge
	always_comb begin
		tx_next = tx_reg;
		if (tx_reg.idx != dsas_pkg::END_BIT) begin
			tx_next.idx = tx_reg.idx + 5'h01;
		end
	end

	always_ff @(negedge i_serial_clock or posedge i_read_n) begin
		if (i_read_n) begin
			tx_reg <= '0;
		end else begin
			tx_reg <= tx_next;
		end
	end

	// bit 17 of the word is sent first; zeros once exhausted
	always_comb begin
		o_dout = 1'b0;
		if (tx_reg.idx <= dsas_pkg::LAST_BIT) begin
			o_dout = lnk.word[dsas_pkg::LAST_BIT - tx_reg.idx];
		end
	end
	assign o_dout_oe_n = i_read_n;

	// ------------------------------------------------------------
	// input side, samples on rising serial clock edges
	// ------------------------------------------------------------
	typedef struct packed {
		logic [15:0] shift;
	} dsas_rx_st_t;
	dsas_rx_st_t rx_reg;
	dsas_rx_st_t rx_next;

	// the serial clock may stand still, so only a constant clear
	// is taken from the system reset here
	always_comb begin
		rx_next = rx_reg;
		if (!i_read_n) begin
			rx_next.shift = {rx_reg.shift[14:0], i_serial_din};
		end
	end

	always_ff @(posedge i_serial_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			rx_reg <= '0;
		end else begin
			rx_reg <= rx_next;
		end
	end
	assign o_rx_word = rx_reg.shift;

endmodule

// ---- verification/dsas_conv_model.sv ----
// behavioural model of the integrating converter's comparator
// assumes phase outputs are registered on the system clock rising edge
`timescale 1ns/10ps
module dsas_conv_model (
	// clock and phase selects
	input  wire logic        i_clk,
	input  wire logic        i_phase_upper,
	input  wire logic        i_phase_lower,
	// scenario controls, zero fall count means the comparator never falls
	input  wire logic        i_pos,
	input  wire logic [16:0] i_fall_at,
	// comparator output
	output logic             o_zero_cross_in
);
	// ------------------------------------------------------------
	// comparator
	// ------------------------------------------------------------
	int cnt = 0;
	initial o_zero_cross_in = 1'b1;

	// rundown counts, other phases show the input polarity
	always @(negedge i_clk) begin
		if ({i_phase_upper, i_phase_lower} == 2'h3) begin
			cnt <= cnt + 1;
			// a fall only comes when the input was positive
			if (i_fall_at != 0 && cnt + 1 >= i_fall_at) begin
				o_zero_cross_in <= 1'b0;
			end
		end else begin
			cnt <= 0;
			o_zero_cross_in <= i_pos;
		end
	end
endmodule

// ---- verification/dsas_top_test.sv ----
// self-checking bench for the dual-slope sequencer top
// assumes the comparator model stands on the converter side
`timescale 1ns/10ps
module dsas_top_test;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	localparam logic [15:0] TX = 16'ha5c3;
	logic        clk     = 1'b0;
	logic        rst     = 1'b0;
	logic        start_n = 1'b0;
	logic        sclk    = 1'b0;
	logic        read_n  = 1'b0;
	logic        din     = 1'b0;
	logic        pos     = 1'b1;
	logic [16:0] fall_at = 17'h0_0000;
	logic [17:0] w;
	logic [15:0] lo, hi;
	logic        ofl_x, sgn_x;
	logic        zc, ph_u, ph_l, rdy, dout, oe_n;
	logic [15:0] rx;
	int          err_total = 0;
	int          compares  = 0;
	int          cyc       = 0;
	int          len;

	// shortened counts keep the run brief
	dsas_top #(.P_AZ_CYCLES(200), .P_CLR_CYCLES(20), .P_INT_CYCLES(64)) u_dut (
		.i_clk(clk), .i_sys_rst(rst), .i_start_n(start_n),
		.i_zero_cross_in(zc), .o_phase_upper(ph_u), .o_phase_lower(ph_l),
		.o_result_ready(rdy), .i_serial_clock(sclk), .i_read_n(read_n),
		.i_serial_din(din), .o_dout(dout), .o_dout_oe_n(oe_n),
		.o_rx_word(rx));

	dsas_conv_model u_conv (
		.i_clk(clk), .i_phase_upper(ph_u), .i_phase_lower(ph_l),
		.i_pos(pos), .i_fall_at(fall_at), .o_zero_cross_in(zc));

	// ------------------------------------------------------------
	// clock, timeout and shared tasks
	// ------------------------------------------------------------
	always #25 clk = ~clk;

	// overflow rundown alone takes about 65.6k cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 75000) begin
			err_total++;
			$display("[ERR] %0t run hung", $time);
			conclude();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic wait_ph(input logic [1:0] c);
		for (int k = 0; k < 70000 && {ph_u, ph_l} !== c; k++) begin
			@(negedge clk);
		end
	endtask

	task automatic hold(input logic [1:0] c);
		len = 0;
		while ({ph_u, ph_l} === c) begin
			@(negedge clk);
			len++;
		end
	endtask

	// serial read, 15 ns serial clock only inside the access
	task automatic rd(input int nb);
		@(negedge clk);
		read_n = 1'b0;
		#5 w[17] = dout;
		chk(oe_n, 1'b0);
		for (int i = 0; i < nb; i++) begin
			din = (i < 2) ? 1'b0 : TX[17-i];
			#7.5;
			if (i > 0) begin
				w[17-i] = dout;
			end
			sclk = 1'b1;
			#7.5 sclk = 1'b0;
		end
		#7.5;
		if (nb == 18) begin
			chk(dout, 1'b0);
		end
		@(negedge clk);
		read_n = 1'b1;
		#1 chk(oe_n, 1'b1);
	endtask

	// ------------------------------------------------------------
	// one conversion: check the previous word, then phase timing
	// ------------------------------------------------------------
	task automatic conv(input logic [16:0] n, input logic p);
		wait_ph(2'h2);
		chk(rdy, 1'b1);
		start_n = 1'b1;
		repeat (5) @(negedge clk);
		rd(6);
		rd(18);
		chk(w[17:16], {ofl_x, sgn_x});
		chk(w[15:0] >= lo && w[15:0] <= hi, 1'b1);
		chk(rdy, 1'b0);
		chk(rx, TX);
		pos = p;
		fall_at = n;
		wait_ph(2'h3);
		hold(2'h3);
		chk({ph_u, ph_l}, 2'h0);
		if (n == 0) begin
			chk(len >= 65535, 1'b1);
		end
		// start requested early must not shorten the clear phase
		start_n = 1'b0;
		hold(2'h0);
		chk(len, 20);
		chk({ph_u, ph_l}, 2'h1);
		ofl_x = (n == 0);
		sgn_x = p;
		lo = (n == 0) ? 16'hffff : 16'(n - 1);
		hi = (n == 0) ? 16'hffff : 16'(n + 4);
		$display("test conversion done");
	endtask

	// start held low all along is refused until power-up ends
	task automatic powerup();
		hold(2'h1);
		chk(len >= 200 && len <= 204, 1'b1);
		$display("test power-up done");
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		{ofl_x, sgn_x, lo, hi} = '0;
		// rise after time zero so the asynchronous clears see an edge
		#1;
		rst    = 1'b1;
		read_n = 1'b1;
		repeat (12) @(negedge clk);
		rst = 1'b0;
		powerup();
		conv(17'h0_000a, 1'b1);
		conv(17'h0_012c, 1'b1);
		conv(17'h0_0000, 1'b0);
		conv(17'h0_0005, 1'b1);
		conv(17'h0_0007, 1'b1);
		conclude();
	end
endmodule
